/* File: cpx_core.sv */
// Execution core for jumps, stack/status loads, byte and word moves and multiply
//
// Summary of operation
// - Opcode 00 jumps to next address plus signed byte; 7 cycles; flags kept.
// - The displacement is the second byte, reaching -128 to +127.
// - Long jump adds 16-bit offset: immediate 89, pair 99, immediate plus B A9.
// - Opcode FD copies B into the stack pointer in 7 cycles, flags kept.
// - Opcode F0 loads its immediate byte into the status register in 6 cycles.
// - Interrupt enable/disable are just F0 with a constant; no other opcodes.
// - Byte move copies value, clears carry and overflow, sets negative and zero.
// - Memory-mode moves go only through A; stack-relative F1/F2 take 7 cycles.
// - Register/peripheral moves hold their two operand bytes in reversed order.
// - Moves naming A or B use one- or two-byte encodings, except direct and indexed memory moves (three bytes).
// - Word move: destination is low byte, minus one high; flags from high.
// - Opcode A8 stores B plus 16-bit constant itself in the pair; 15 cycles.
// - Multiply stores 16-bit product in A:B, A high; 45 to 48 cycles.
// - After multiply carry clears and negative follows register A.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "cpx_defines.svh"

module cpx_core #(
    parameter int MEM_AW = 8
) (
    input wire logic pclk, // APB clock
    input wire logic presetn, // Asynchronous reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    output logic busy // Instruction in progress
);
    cpx_pkg::cpx_state_t state_q;
    cpx_pkg::cpx_instr_t ins_q;
    cpx_pkg::cpx_dec_t dec;
    cpx_pkg::cpx_dst_t dk;
    logic [5:0] cnt_q;
    logic [15:0] pc_q, pc_d, next_instruction_address, da, w16;
    logic [7:0] stk_q, stk_d, stat_q, stat_d, rfidx_q, val, wdst, mula, mulb;
    logic [7:0] b1, b2, b3, reg_a, reg_b;
    logic ill_q, exe, start, wr, rd_setup, rf_wr, unmapped, locked;
    logic [31:0] rdmux, prdata_q;
    logic [7:0] rf [256];
    logic [7:0] pf [256];
    logic [7:0] dm [2**MEM_AW];

    function automatic cpx_pkg::cpx_dec_t decode(input logic [7:0] op);
        cpx_pkg::cpx_dec_t d;
        d = {1'b0, 3'd1, 6'd1};
        case (op)
            `CPX_OP_SRJ: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_LRJ_IMM: d = {1'b1, 3'd3, 6'd9};
            `CPX_OP_LRJ_RP: d = {1'b1, 3'd2, 6'd8};
            `CPX_OP_LRJ_IDX: d = {1'b1, 3'd3, 6'd11};
            `CPX_OP_LDSTK: d = {1'b1, 3'd1, 6'd7};
            `CPX_OP_LDSTAT: d = {1'b1, 3'd2, 6'd6};
            `CPX_OP_AB: d = {1'b1, 3'd1, 6'd9};
            `CPX_OP_AR: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_BA: d = {1'b1, 3'd1, 6'd8};
            `CPX_OP_BR: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_RA: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_RB: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_RR: d = {1'b1, 3'd3, 6'd9};
            `CPX_OP_IA: d = {1'b1, 3'd2, 6'd6};
            `CPX_OP_IB: d = {1'b1, 3'd2, 6'd6};
            `CPX_OP_IR: d = {1'b1, 3'd3, 6'd8};
            `CPX_OP_AP: d = {1'b1, 3'd2, 6'd8};
            `CPX_OP_BP: d = {1'b1, 3'd2, 6'd8};
            `CPX_OP_RP: d = {1'b1, 3'd3, 6'd10};
            `CPX_OP_PA: d = {1'b1, 3'd2, 6'd8};
            `CPX_OP_PB: d = {1'b1, 3'd2, 6'd8};
            `CPX_OP_PR: d = {1'b1, 3'd3, 6'd10};
            `CPX_OP_IP: d = {1'b1, 3'd3, 6'd10};
            `CPX_OP_A_DIR: d = {1'b1, 3'd3, 6'd10};
            `CPX_OP_DIR_A: d = {1'b1, 3'd3, 6'd12};
            `CPX_OP_A_IND: d = {1'b1, 3'd2, 6'd9};
            `CPX_OP_IND_A: d = {1'b1, 3'd2, 6'd9};
            `CPX_OP_A_IDX: d = {1'b1, 3'd3, 6'd12};
            `CPX_OP_IDX_A: d = {1'b1, 3'd3, 6'd12};
            `CPX_OP_A_STK: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_STK_A: d = {1'b1, 3'd2, 6'd7};
            `CPX_OP_W_PAIR: d = {1'b1, 3'd3, 6'd12};
            `CPX_OP_W_IMM: d = {1'b1, 3'd4, 6'd13};
            `CPX_OP_W_IDX: d = {1'b1, 3'd4, 6'd15};
            `CPX_OP_MUL_BA: d = {1'b1, 3'd1, 6'd47};
            `CPX_OP_MUL_RA: d = {1'b1, 3'd2, 6'd46};
            `CPX_OP_MUL_RB: d = {1'b1, 3'd2, 6'd46};
            `CPX_OP_MUL_RR: d = {1'b1, 3'd3, 6'd48};
            `CPX_OP_MUL_IA: d = {1'b1, 3'd2, 6'd45};
            `CPX_OP_MUL_IB: d = {1'b1, 3'd2, 6'd45};
            `CPX_OP_MUL_IR: d = {1'b1, 3'd3, 6'd47};
            default: d = {1'b0, 3'd1, 6'd1};
        endcase
        return d;
    endfunction

    // Register pair: the named register is the low byte, the one below it the high
    function automatic logic [15:0] pair(input logic [7:0] idx);
        return {rf[idx - 8'h01], rf[idx]};
    endfunction

    // Move flags: carry and overflow cleared, negative and zero from the value
    function automatic logic [7:0] mvflags(input logic [7:0] st, input logic [7:0] v);
        logic [7:0] r;
        r = st;
        r[`CPX_BIT_C] = 1'b0;
        r[`CPX_BIT_V] = 1'b0;
        r[`CPX_BIT_N] = v[7];
        r[`CPX_BIT_Z] = (v == 8'h00);
        return r;
    endfunction

    assign b1 = ins_q.b1;
    assign b2 = ins_q.b2;
    assign b3 = ins_q.b3;
    assign reg_a = rf[`CPX_REG_A];
    assign reg_b = rf[`CPX_REG_B];
    assign dec = decode(ins_q.op);
    assign busy = (state_q == cpx_pkg::CPX_EXEC);
    // All architectural effects land on the first busy cycle; the rest is pure timing
    assign exe = busy && (cnt_q == 6'd0) && dec.legal;

    always_comb begin
        next_instruction_address = pc_q + 16'(dec.len);
        pc_d = next_instruction_address;
        stk_d = stk_q;
        stat_d = stat_q;
        dk = cpx_pkg::CPX_D_NONE;
        da = 16'h0000;
        val = 8'h00;
        wdst = `CPX_REG_B;
        w16 = 16'h0000;
        mula = reg_a;
        mulb = reg_b;
        case (ins_q.op)
            `CPX_OP_SRJ: pc_d = next_instruction_address + {{8{b1[7]}}, b1};
            `CPX_OP_LRJ_IMM: pc_d = next_instruction_address + {b1, b2};
            `CPX_OP_LRJ_RP: pc_d = next_instruction_address + pair(b1);
            `CPX_OP_LRJ_IDX: pc_d = next_instruction_address + {b1, b2} + {8'h00, reg_b};
            `CPX_OP_LDSTK: stk_d = reg_b;
            `CPX_OP_LDSTAT: stat_d = b1;
            `CPX_OP_AB: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_B); val = reg_a; end
            `CPX_OP_AR: begin dk = cpx_pkg::CPX_D_RF; da = {8'h00, b1}; val = reg_a; end
            `CPX_OP_BA: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_A); val = reg_b; end
            `CPX_OP_BR: begin dk = cpx_pkg::CPX_D_RF; da = {8'h00, b1}; val = reg_b; end
            `CPX_OP_RA: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_A); val = rf[b1]; end
            `CPX_OP_RB: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_B); val = rf[b1]; end
            `CPX_OP_RR: begin dk = cpx_pkg::CPX_D_RF; da = {8'h00, b2}; val = rf[b1]; end
            `CPX_OP_IA: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_A); val = b1; end
            `CPX_OP_IB: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_B); val = b1; end
            `CPX_OP_IR: begin dk = cpx_pkg::CPX_D_RF; da = {8'h00, b2}; val = b1; end
            `CPX_OP_AP: begin dk = cpx_pkg::CPX_D_PF; da = {8'h00, b1}; val = reg_a; end
            `CPX_OP_BP: begin dk = cpx_pkg::CPX_D_PF; da = {8'h00, b1}; val = reg_b; end
            // Peripheral first, general register second in the encoded bytes
            `CPX_OP_RP: begin dk = cpx_pkg::CPX_D_PF; da = {8'h00, b1}; val = rf[b2]; end
            `CPX_OP_PA: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_A); val = pf[b1]; end
            `CPX_OP_PB: begin dk = cpx_pkg::CPX_D_RF; da = 16'(`CPX_REG_B); val = pf[b1]; end
            `CPX_OP_PR: begin dk = cpx_pkg::CPX_D_RF; da = {8'h00, b1}; val = pf[b2]; end
            `CPX_OP_IP: begin dk = cpx_pkg::CPX_D_PF; da = {8'h00, b2}; val = b1; end
            `CPX_OP_A_DIR: begin dk = cpx_pkg::CPX_D_DM; da = {b1, b2}; val = reg_a; end
            `CPX_OP_DIR_A: begin
                dk = cpx_pkg::CPX_D_RF;
                da = 16'(`CPX_REG_A);
                w16 = {b1, b2};
                val = dm[w16[MEM_AW-1:0]];
            end
            `CPX_OP_A_IND: begin dk = cpx_pkg::CPX_D_DM; da = pair(b1); val = reg_a; end
            `CPX_OP_IND_A: begin
                dk = cpx_pkg::CPX_D_RF;
                da = 16'(`CPX_REG_A);
                w16 = pair(b1);
                val = dm[w16[MEM_AW-1:0]];
            end
            `CPX_OP_A_IDX: begin
                dk = cpx_pkg::CPX_D_DM;
                da = {b1, b2} + {8'h00, reg_b};
                val = reg_a;
            end
            `CPX_OP_IDX_A: begin
                dk = cpx_pkg::CPX_D_RF;
                da = 16'(`CPX_REG_A);
                w16 = {b1, b2} + {8'h00, reg_b};
                val = dm[w16[MEM_AW-1:0]];
            end
            // The stack lives in the register file, so these wrap within it
            `CPX_OP_A_STK: begin
                dk = cpx_pkg::CPX_D_RF;
                da = {8'h00, stk_q + b1};
                val = reg_a;
            end
            `CPX_OP_STK_A: begin
                dk = cpx_pkg::CPX_D_RF;
                da = 16'(`CPX_REG_A);
                val = rf[stk_q + b1];
            end
            `CPX_OP_W_PAIR: begin dk = cpx_pkg::CPX_D_WORD; wdst = b2; w16 = pair(b1); end
            `CPX_OP_W_IMM: begin dk = cpx_pkg::CPX_D_WORD; wdst = b3; w16 = {b1, b2}; end
            `CPX_OP_W_IDX: begin
                dk = cpx_pkg::CPX_D_WORD;
                wdst = b3;
                w16 = {b1, b2} + {8'h00, reg_b};
            end
            // A-forms multiply by A, not by the B default
            `CPX_OP_MUL_RA: begin mula = rf[b1]; mulb = reg_a; end
            `CPX_OP_MUL_RB: mula = rf[b1];
            `CPX_OP_MUL_RR: begin mula = rf[b1]; mulb = rf[b2]; end
            `CPX_OP_MUL_IA: begin mula = b1; mulb = reg_a; end
            `CPX_OP_MUL_IB: mula = b1;
            `CPX_OP_MUL_IR: begin mula = b1; mulb = rf[b2]; end
            default: ;
        endcase
        // Product goes to the A:B pair, which is the pair named by B
        if (ins_q.op[3:0] == 4'hc && dec.legal) begin
            dk = cpx_pkg::CPX_D_WORD;
            wdst = `CPX_REG_B;
            w16 = 16'(mula) * 16'(mulb);
        end
        if (dk == cpx_pkg::CPX_D_WORD) begin
            stat_d = mvflags(stat_q, w16[15:8]);
        end else if (dk != cpx_pkg::CPX_D_NONE) begin
            stat_d = mvflags(stat_q, val);
        end
    end

    assign start = wr && (paddr == `CPX_OFF_INSTR) && !busy;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= cpx_pkg::CPX_IDLE;
            cnt_q <= 6'd0;
            ins_q <= '0;
        end else if (start) begin
            state_q <= cpx_pkg::CPX_EXEC;
            cnt_q <= 6'd0;
            ins_q <= pwdata;
        end else if (busy) begin
            // Hold busy for the full listed count, not just until the write lands
            if (!dec.legal || cnt_q == dec.cyc - 6'd1) begin
                state_q <= cpx_pkg::CPX_IDLE;
                cnt_q <= 6'd0;
            end else begin
                cnt_q <= cnt_q + 6'd1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= `CPX_RST_PC;
            stk_q <= `CPX_RST_STK;
            stat_q <= `CPX_RST_STAT;
        end else if (exe) begin
            pc_q <= pc_d;
            stk_q <= stk_d;
            stat_q <= stat_d;
        end else if (wr && !busy && paddr == `CPX_OFF_PC) begin
            pc_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ill_q <= 1'b0;
        end else if (busy && cnt_q == 6'd0 && !dec.legal) begin
            ill_q <= 1'b1;
        end else if (start) begin
            ill_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rfidx_q <= 8'h00;
        end else if (wr && paddr == `CPX_OFF_RFIDX) begin
            rfidx_q <= pwdata[7:0];
        end
    end

    assign rf_wr = wr && !busy && paddr == `CPX_OFF_RFDAT;

    // Storage arrays carry no reset; software initialises what it uses
    always_ff @(posedge pclk) begin
        if (exe && dk == cpx_pkg::CPX_D_RF) begin
            rf[da[7:0]] <= val;
        end
        if (exe && dk == cpx_pkg::CPX_D_WORD) begin
            rf[wdst] <= w16[7:0];
            rf[wdst - 8'h01] <= w16[15:8];
        end
        if (rf_wr) begin
            rf[rfidx_q] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk) begin
        if (exe && dk == cpx_pkg::CPX_D_PF) begin
            pf[da[7:0]] <= val;
        end
    end

    always_ff @(posedge pclk) begin
        if (exe && dk == cpx_pkg::CPX_D_DM) begin
            dm[da[MEM_AW-1:0]] <= val;
        end
    end

    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable;

    always_comb begin
        unmapped = 1'b0;
        rdmux = 32'h0000_0000;
        if (paddr == `CPX_OFF_INSTR) begin
            rdmux = ins_q;
        end else if (paddr == `CPX_OFF_STAT) begin
            rdmux = {8'h00, stk_q, stat_q, 6'h00, ill_q, busy};
        end else if (paddr == `CPX_OFF_PC) begin
            rdmux = {16'h0000, pc_q};
        end else if (paddr == `CPX_OFF_RFIDX) begin
            rdmux = {24'h00_0000, rfidx_q};
        end else if (paddr == `CPX_OFF_RFDAT) begin
            rdmux = {24'h00_0000, rf[rfidx_q]};
        end else begin
            unmapped = 1'b1;
        end
    end

    // Read data is captured in the setup phase so zero-wait reads come from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_q <= rdmux;
        end
    end

    assign locked = busy && (paddr == `CPX_OFF_INSTR || paddr == `CPX_OFF_PC
                             || paddr == `CPX_OFF_RFDAT);
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && (unmapped || (pwrite && locked));

    // Checks
    logic [6:0] bcnt_q;
    logic [15:0] wpair;
    // A process, not an assign, so that register file writes re-evaluate the pair
    always_comb begin
        wpair = pair(b3);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bcnt_q <= 7'd0;
        end else if (start) begin
            bcnt_q <= 7'd0;
        end else if (busy) begin
            bcnt_q <= bcnt_q + 7'd1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_start_exec;
        start ##1 exe;
    endsequence

    busy_len_a: assert property ($fell(busy) |-> bcnt_q == 7'(dec.legal ? dec.cyc : 6'd1))
        else $error("instruction busy time differs from its cycle count");
    short_jump_a: assert property (exe && ins_q.op == `CPX_OP_SRJ |=>
        pc_q == $past(pc_q) + 16'd2 + {{8{$past(b1[7])}}, $past(b1)})
        else $error("short jump target wrong");
    long_jump_a: assert property (exe && ins_q.op == `CPX_OP_LRJ_IMM |=>
        pc_q == $past(pc_q) + 16'd3 + {$past(b1), $past(b2)})
        else $error("long jump target wrong");
    jump_flags_a: assert property (exe && (ins_q.op == `CPX_OP_SRJ
        || ins_q.op == `CPX_OP_LRJ_RP || ins_q.op == `CPX_OP_LDSTK) |=> $stable(stat_q))
        else $error("jump or stack load changed status");
    load_stack_a: assert property (exe && ins_q.op == `CPX_OP_LDSTK |=> stk_q == $past(reg_b))
        else $error("stack pointer not loaded from B");
    load_status_a: assert property (exe && ins_q.op == `CPX_OP_LDSTAT |=> stat_q == $past(b1))
        else $error("status not loaded from immediate");
    move_flags_a: assert property (exe && dk inside {cpx_pkg::CPX_D_RF, cpx_pkg::CPX_D_PF,
        cpx_pkg::CPX_D_DM} |=> !stat_q[`CPX_BIT_C] && !stat_q[`CPX_BIT_V]
        && stat_q[`CPX_BIT_Z] == ($past(val) == 8'h00) && stat_q[`CPX_BIT_N] == $past(val[7]))
        else $error("byte move flags wrong");
    index_word_a: assert property (exe && ins_q.op == `CPX_OP_W_IDX |=>
        wpair == {$past(b1), $past(b2)} + {8'h00, $past(reg_b)})
        else $error("indexed word move sum wrong");
    mult_result_a: assert property (s_start_exec ##0 (ins_q.op[3:0] == 4'hc) |=>
        {reg_a, reg_b} == 16'($past(mula)) * 16'($past(mulb)) && stat_q[`CPX_BIT_N] == reg_a[7]
        && !stat_q[`CPX_BIT_C])
        else $error("multiply result or flags wrong");
endmodule

/* File: cpx_defines.svh */
// Register offsets, status bit positions, reset values and opcodes of the execution core
`ifndef CPX_DEFINES_SVH
`define CPX_DEFINES_SVH

`define CPX_OFF_INSTR 8'h00
`define CPX_OFF_STAT 8'h04
`define CPX_OFF_PC 8'h08
`define CPX_OFF_RFIDX 8'h0c
`define CPX_OFF_RFDAT 8'h10

`define CPX_BIT_C 7
`define CPX_BIT_N 6
`define CPX_BIT_Z 5
`define CPX_BIT_V 4
`define CPX_BIT_IE2 3
`define CPX_BIT_IE1 2

`define CPX_RST_PC 16'h0000
`define CPX_RST_STK 8'h01
`define CPX_RST_STAT 8'h00
`define CPX_REG_A 8'h00
`define CPX_REG_B 8'h01

`define CPX_OP_SRJ 8'h00
`define CPX_OP_LRJ_IMM 8'h89
`define CPX_OP_LRJ_RP 8'h99
`define CPX_OP_LRJ_IDX 8'ha9
`define CPX_OP_LDSTK 8'hfd
`define CPX_OP_LDSTAT 8'hf0
`define CPX_OP_AB 8'hc0
`define CPX_OP_AR 8'hd0
`define CPX_OP_BA 8'h62
`define CPX_OP_BR 8'hd1
`define CPX_OP_RA 8'h12
`define CPX_OP_RB 8'h32
`define CPX_OP_RR 8'h42
`define CPX_OP_IA 8'h22
`define CPX_OP_IB 8'h52
`define CPX_OP_IR 8'h72
`define CPX_OP_AP 8'h21
`define CPX_OP_BP 8'h51
`define CPX_OP_RP 8'h71
`define CPX_OP_PA 8'h80
`define CPX_OP_PB 8'h91
`define CPX_OP_PR 8'ha2
`define CPX_OP_IP 8'hf7
`define CPX_OP_A_DIR 8'h8b
`define CPX_OP_DIR_A 8'h8a
`define CPX_OP_A_IND 8'h9b
`define CPX_OP_IND_A 8'h9a
`define CPX_OP_A_IDX 8'hab
`define CPX_OP_IDX_A 8'haa
`define CPX_OP_A_STK 8'hf2
`define CPX_OP_STK_A 8'hf1
`define CPX_OP_W_PAIR 8'h98
`define CPX_OP_W_IMM 8'h88
`define CPX_OP_W_IDX 8'ha8
`define CPX_OP_MUL_BA 8'h6c
`define CPX_OP_MUL_RA 8'h1c
`define CPX_OP_MUL_RB 8'h3c
`define CPX_OP_MUL_RR 8'h4c
`define CPX_OP_MUL_IA 8'h2c
`define CPX_OP_MUL_IB 8'h5c
`define CPX_OP_MUL_IR 8'h7c

`endif

/* File: cpx_pkg.sv */
// Types shared by the execution core
package cpx_pkg;
    typedef struct packed {
        logic [7:0] b3;
        logic [7:0] b2;
        logic [7:0] b1;
        logic [7:0] op;
    } cpx_instr_t;
    typedef struct packed {
        logic legal;
        logic [2:0] len;
        logic [5:0] cyc;
    } cpx_dec_t;
    typedef enum logic {CPX_IDLE = 1'b0, CPX_EXEC = 1'b1} cpx_state_t;
    typedef enum logic [2:0] {
        CPX_D_NONE, CPX_D_RF, CPX_D_PF, CPX_D_DM, CPX_D_WORD
    } cpx_dst_t;
endpackage

/* File: tb_cpu_jump_move_multiply_ops.sv */
// Self-checking bench for the jump, load, move and multiply core
`timescale 1ns/1ps
module tb_cpu_jump_move_multiply_ops;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic busy;
    logic [31:0] rv;
    logic ev;
    int mismatches = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] sv [4] = '{8'hff, 8'h00, 8'h0c, 8'h8c};

    cpx_core #(.MEM_AW(8)) uut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(busy)
    );

    always #2.5 pclk = ~pclk;

    task automatic close_out;
        $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Whole run needs well under 3000 cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches++;
            $display("CHECK FAILED t=%0t run timed out", $time);
            close_out();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic setr(input logic [7:0] i, input logic [7:0] v);
        apb(1'b1, 8'h0c, {24'h0, i});
        apb(1'b1, 8'h10, {24'h0, v});
    endtask

    task automatic getr(input logic [7:0] i, input logic [7:0] v);
        apb(1'b1, 8'h0c, {24'h0, i});
        apb(1'b0, 8'h10, 32'h0);
        check(rv, {24'h0, v});
    endtask

    task automatic stat(input logic [7:0] sp, input logic [7:0] st);
        apb(1'b0, 8'h04, 32'h0);
        check(rv, {8'h00, sp, st, 8'h00});
    endtask

    task automatic pc(input logic [15:0] v);
        apb(1'b0, 8'h08, 32'h0);
        check(rv, {16'h0, v});
    endtask

    // Counts the cycles busy stays high after the starting write
    task automatic run(input logic [31:0] ins, input logic [31:0] n);
        logic [31:0] k;
        k = 0;
        apb(1'b1, 8'h00, ins);
        #1;
        while (busy === 1'b1 && k < 100) begin
            @(posedge pclk);
            #1;
            k++;
        end
        check(k, n);
    endtask

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        stat(8'h01, 8'h00);
        pc(16'h0000);
        setr(8'h00, 8'hff);
        setr(8'h01, 8'h80);
        run(32'h0000_00fd, 7);
        stat(8'h80, 8'h00);
        foreach (sv[i]) begin
            run({16'h0, sv[i], 8'hf0}, 6);
            stat(8'h80, sv[i]);
        end
        $display("Test loads done");
        apb(1'b1, 8'h08, 32'h0000_1000);
        run(32'h0000_8000, 7);
        pc(16'h0f82);
        run(32'h0000_7f00, 7);
        pc(16'h1003);
        run(32'h0034_1289, 9);
        pc(16'h223a);
        run(32'h00f0_ffa9, 11);
        pc(16'h22ad);
        stat(8'h80, 8'h8c);
        $display("Test jumps done");
        setr(8'h05, 8'h80);
        run(32'h0005_0371, 10);
        run(32'h0003_06a2, 10);
        getr(8'h06, 8'h80);
        stat(8'h80, 8'h4c);
        run(32'h0000_0022, 6);
        getr(8'h00, 8'h00);
        stat(8'h80, 8'h2c);
        setr(8'h00, 8'h5a);
        run(32'h0000_05f2, 7);
        getr(8'h85, 8'h5a);
        setr(8'h00, 8'h00);
        run(32'h0000_05f1, 7);
        getr(8'h00, 8'h5a);
        run(32'h0000_0062, 8);
        getr(8'h00, 8'h80);
        stat(8'h80, 8'h4c);
        $display("Test byte moves done");
        run(32'h0a01_8088, 13);
        getr(8'h09, 8'h80);
        getr(8'h0a, 8'h01);
        run(32'h0cf0_12a8, 15);
        getr(8'h0b, 8'h13);
        getr(8'h0c, 8'h70);
        stat(8'h80, 8'h0c);
        run(32'h000e_0a98, 12);
        getr(8'h0d, 8'h80);
        getr(8'h0e, 8'h01);
        apb(1'b1, 8'h08, 32'h0000_1000);
        run(32'h0000_0a99, 8);
        pc(16'h9003);
        stat(8'h80, 8'h4c);
        $display("Test word moves done");
        run(32'h0000_8cf0, 6);
        setr(8'h00, 8'hff);
        setr(8'h01, 8'hff);
        run(32'h0000_006c, 47);
        getr(8'h00, 8'hfe);
        getr(8'h01, 8'h01);
        stat(8'h80, 8'h4c);
        run(32'h0006_054c, 48);
        getr(8'h00, 8'h40);
        getr(8'h01, 8'h00);
        stat(8'h80, 8'h0c);
        run(32'h0000_032c, 45);
        getr(8'h00, 8'h00);
        getr(8'h01, 8'hc0);
        stat(8'h80, 8'h2c);
        setr(8'h00, 8'h03);
        run(32'h0000_051c, 46);
        getr(8'h00, 8'h01);
        getr(8'h01, 8'h80);
        stat(8'h80, 8'h0c);
        run(32'h003c_128b, 10);
        setr(8'h00, 8'h00);
        run(32'h003c_128a, 12);
        getr(8'h00, 8'h01);
        $display("Test multiply done");
        // Unmapped and unaligned places answer zero with an error
        apb(1'b0, 8'h14, 32'h0);
        check({rv[31:1], ~ev}, 32'h0);
        apb(1'b0, 8'h02, 32'h0);
        check({rv[31:1], ~ev}, 32'h0);
        run(32'h0000_00f4, 1);
        apb(1'b0, 8'h04, 32'h0);
        check(rv, 32'h0080_0c02);
        $display("Test errors done");
        close_out();
    end
endmodule
